// ---- pkg/pis_pkg.sv ----
package pis_pkg;

  // ==========================================================================
  // Link figures
  localparam int BITS_PER_BYTE = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [6:0] DEVICE_BUS_ADDRESS = 7'h60;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ==========================================================================
  // Timing
  localparam int SYS_CLK_HZ = 10000000;
  localparam int MAX_BIT_RATE_BPS = 400000;
  // System clocks per bit at the fastest legal link rate
  localparam int SCL_MIN_PERIOD_CYC = SYS_CLK_HZ / MAX_BIT_RATE_BPS;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // Register file
  localparam int NUM_REGS = 14;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h43, 8'h00
  };

  // ==========================================================================
  // Transfer states, Gray coded along idle, address, register, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_REG = 3'h3,
    ST_DATA = 3'h2,
    ST_READ = 3'h6,
    ST_IGNORE = 3'h4
  } pis_state_t;

endpackage : pis_pkg

// ---- design/pis_sync.sv ----
`timescale 1ns/10ps

module pis_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  // ==========================================================================
  // Two-stage synchroniser plus one history stage for edge finding
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] hist_r;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
          hist_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= din_i[gi];
          sync_r[gi] <= meta_r[gi];
          hist_r[gi] <= sync_r[gi];
        end
      end
      // Edges compare second and third stages only, never the first
      assign rise_o[gi] = sync_r[gi] & ~hist_r[gi];
      assign fall_o[gi] = ~sync_r[gi] & hist_r[gi];
      assign level_o[gi] = sync_r[gi];
    end
  endgenerate

endmodule : pis_sync

// ---- design/pis_i2c_slave.sv ----
`timescale 1ns/10ps

// Summary of operation
// R1: Target only, timed by master's SCL edges
// R2: Works at any rate to 400 kbit/s
// R3: SDA changes only while SCL low
// R4: SDA fall/rise with SCL high: START/STOP
// R5: Busy from START until STOP
// R6: Repeated START restarts address recognition
// R7: Eight bits per byte, MSB first
// R8: Ninth clock acknowledges; target acks received bytes
// R9: First byte: seven-bit address, direction bit
// R10: Write: register byte, then data byte
// R11: Fixed bus address 60h
// R12: Master writes register address before reading
// R13: Unlimited register/data pairs until STOP
// R14: Silent during charger standby
// R15: Fourteen registers, reset to defaults
// R16: Read phase returns addressed register
// R17: Address mismatch: no ack, ignore until START
// R18: Master ends read with nack, STOP

module pis_i2c_slave #(
  parameter int NUM_REGS = pis_pkg::NUM_REGS,
  parameter logic [6:0] BUS_ADDR = pis_pkg::DEVICE_BUS_ADDRESS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic standby_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic bus_busy_o,
  output logic wr_strobe_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [NUM_REGS*8-1:0] reg_flat_o
);

  // ==========================================================================
  // Helpers
  function automatic logic pis_in_range(input logic [7:0] a);
    pis_in_range = (32'(a) < NUM_REGS);
  endfunction : pis_in_range

  function automatic logic pis_is_read(input pis_pkg::pis_state_t st);
    pis_is_read = (st == pis_pkg::ST_READ);
  endfunction : pis_is_read

  function automatic logic pis_addr_hit(input logic [7:0] b);
    pis_addr_hit = (b[7:1] == BUS_ADDR);
  endfunction : pis_addr_hit

  // ==========================================================================
  // Pin sampling
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // SCL is sampled, never used as a clock; 25 cycles per bit at top speed
  pis_sync #(.WIDTH(2)) u_sync ( // R1 R2
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .din_i({scl_i, sda_i}),
    .level_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  assign scl_lvl = lvl[1];
  assign sda_lvl = lvl[0];
  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  // Both pins share one pipeline, so their order is kept
  assign start_det = scl_lvl & fall[0]; // R4
  assign stop_det = scl_lvl & rise[0]; // R4

  // ==========================================================================
  // Transfer sequencing
  pis_pkg::pis_state_t state_r;
  logic [pis_pkg::BIT_CNT_W-1:0] bit_cnt_r;
  logic ack_phase_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic sda_oe_n_r;
  logic [7:0] ptr_r;
  logic [NUM_REGS-1:0][7:0] regs_r;
  logic active;
  logic byte_done;
  logic ack_end;
  logic [7:0] rd_byte;

  assign active = (state_r != pis_pkg::ST_IDLE) && (state_r != pis_pkg::ST_IGNORE);
  assign byte_done = active & scl_fall & ~ack_phase_r
                     & (32'(bit_cnt_r) == pis_pkg::BITS_PER_BYTE); // R7
  assign ack_end = active & scl_fall & ack_phase_r;
  assign rd_byte = pis_in_range(ptr_r) ? regs_r[ptr_r[3:0]] : pis_pkg::UNMAPPED_READ; // R16

  // Drive changes as soon as the SCL fall is seen, early in the low phase
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || standby_i) begin // R14
      state_r <= pis_pkg::ST_IDLE;
      bit_cnt_r <= '0;
      ack_phase_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
    end else if (start_det) begin // R6
      state_r <= pis_pkg::ST_ADDR; // R5
      bit_cnt_r <= '0;
      ack_phase_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= pis_pkg::ST_IDLE; // R5
      ack_phase_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (active) begin
      if (scl_rise) begin
        if (!ack_phase_r) begin
          shift_r <= {shift_r[6:0], sda_lvl}; // R7
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end else if (pis_is_read(state_r) && sda_oe_n_r && sda_lvl) begin
          // Master declined the byte: stay off the bus until STOP or START
          state_r <= pis_pkg::ST_IGNORE; // R18
        end
      end else if (ack_end) begin
        ack_phase_r <= 1'b0;
        bit_cnt_r <= '0;
        if (pis_is_read(state_r)) begin
          tx_r <= rd_byte; // R16
          sda_oe_n_r <= rd_byte[7]; // R3
        end else begin
          sda_oe_n_r <= 1'b1; // R3
        end
      end else if (byte_done) begin
        ack_phase_r <= 1'b1; // R8
        case (state_r)
          pis_pkg::ST_ADDR: begin
            if (pis_addr_hit(shift_r)) begin // R9 R11
              sda_oe_n_r <= 1'b0; // R8
              state_r <= (shift_r[0] == pis_pkg::RW_READ) ? pis_pkg::ST_READ
                                                           : pis_pkg::ST_REG; // R9
            end else begin
              state_r <= pis_pkg::ST_IGNORE; // R17
              sda_oe_n_r <= 1'b1;
            end
          end
          pis_pkg::ST_REG: begin
            sda_oe_n_r <= 1'b0; // R8
            state_r <= pis_pkg::ST_DATA; // R10
          end
          pis_pkg::ST_DATA: begin
            sda_oe_n_r <= 1'b0; // R8
            state_r <= pis_pkg::ST_REG; // R13
          end
          pis_pkg::ST_READ: begin
            sda_oe_n_r <= 1'b1; // R8
          end
          default: begin
            sda_oe_n_r <= 1'b1;
            state_r <= pis_pkg::ST_IDLE;
          end
        endcase
      end else if (scl_fall && pis_is_read(state_r)) begin
        // Next data bit goes out right after SCL falls, held through high
        sda_oe_n_r <= tx_r[6]; // R3 R7
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // Register pointer
  // Reads walk forward through the file so a long read stays useful
  // Standby leaves the pointer alone; only reset clears it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ptr_r <= pis_pkg::PTR_RESET;
    end else if (byte_done && state_r == pis_pkg::ST_REG) begin
      ptr_r <= shift_r; // R10 R12
    end else if (ack_end && pis_is_read(state_r)) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // ==========================================================================
  // Register file
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      regs_r <= pis_pkg::REG_RESET; // R15
      wr_strobe_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else begin
      wr_strobe_o <= 1'b0;
      if (byte_done && state_r == pis_pkg::ST_DATA) begin
        // Data to an unmapped index is still acknowledged and strobed out, but not stored
        if (pis_in_range(ptr_r)) begin
          regs_r[ptr_r[3:0]] <= shift_r; // R10 R13 R15
        end
        wr_strobe_o <= 1'b1;
        wr_addr_o <= ptr_r;
        wr_data_o <= shift_r;
      end
    end
  end

  // ==========================================================================
  // Outputs
  // Open drain: the value stays low and only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_n_o = sda_oe_n_r;
  assign bus_busy_o = (state_r != pis_pkg::ST_IDLE); // R5
  assign reg_flat_o = regs_r;

endmodule : pis_i2c_slave

// ---- test/pis_i2c_checker.sv ----
`timescale 1ns/10ps
// ========
// Port checker
module pis_i2c_checker #(
  parameter int NUM_REGS = pis_pkg::NUM_REGS,
  parameter logic [6:0] BUS_ADDR = pis_pkg::DEVICE_BUS_ADDRESS
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic standby_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic bus_busy_o,
  input wire logic wr_strobe_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [NUM_REGS*8-1:0] reg_flat_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  a_sda_zero: assert property (sda_o == 1'b0)
    else $error("sda value high");
  a_reset_state: assert property ($fell(reset_i) |-> sda_oe_n_o && !bus_busy_o
    && reg_flat_o == pis_pkg::REG_RESET) else $error("bad reset state");
  a_strobe_once: assert property (wr_strobe_o |=> !wr_strobe_o)
    else $error("strobe too long");
  a_reg_stored: assert property (wr_strobe_o && wr_addr_o < NUM_REGS |->
    ##[0:1] reg_flat_o[wr_addr_o*8+:8] == wr_data_o) else $error("data not stored");
  // SDA drive, ack or data, must never move while SCL is high, or it forges a START or STOP
  a_oe_scl_low: assert property (!$stable(sda_oe_n_o) |-> !scl_i)
    else $error("sda drive moved, scl high");
  a_start_busy: assert property (scl_i && $fell(sda_i) && !standby_i |->
    ##[1:6] bus_busy_o) else $error("start missed");
  a_stop_idle: assert property (scl_i && $rose(sda_i) && !standby_i |->
    ##[1:6] !bus_busy_o) else $error("stop missed");
  a_standby_quiet: assert property (standby_i [*2] |-> sda_oe_n_o && !bus_busy_o)
    else $error("active in standby");
endmodule : pis_i2c_checker

bind pis_i2c_slave pis_i2c_checker #(.NUM_REGS(NUM_REGS), .BUS_ADDR(BUS_ADDR)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
  .standby_i(standby_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .bus_busy_o(bus_busy_o),
  .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .reg_flat_o(reg_flat_o));

// ---- test/pis_master_model.sv ----
`timescale 1ns/10ps
// ========
// Bus master, SCL stands high between frames
module pis_master_model (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tk
  // 800 ns per bit, faster than the 400 kbit/s rate ceiling; SDA moves mid low phase
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    tk(2);
    scl_o <= 1'b1;
    tk(2);
    r = sda_i;
    tk(2);
    scl_o <= 1'b0;
    tk(2);
  endtask : bit_x
  task automatic start;
    sda_o <= 1'b1;
    tk(2);
    scl_o <= 1'b1;
    tk(4);
    sda_o <= 1'b0;
    tk(4);
    scl_o <= 1'b0;
    tk(2);
  endtask : start
  task automatic stop;
    sda_o <= 1'b0;
    tk(2);
    scl_o <= 1'b1;
    tk(4);
    sda_o <= 1'b1;
    tk(4);
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
    output logic a);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ai, a);
  endtask : xfer
endmodule : pis_master_model

// ---- test/test_pmic_i2c_register_slave.sv ----
`timescale 1ns/10ps
// ========
// Bench top
module test_pmic_i2c_register_slave;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic standby_i = 1'b0;
  logic scl, sda_m, sda_o, sda_oe_n_o, bus_busy_o, wr_strobe_o, ack;
  logic [7:0] wr_addr_o, wr_data_o, rx, ra, d;
  logic [7:0] shadow [16];
  logic [pis_pkg::NUM_REGS*8-1:0] reg_flat_o;
  logic [15:0] exp_q [$];
  int err_total = 0;
  int n_checks = 0;
  wire sda = sda_m & (sda_oe_n_o | sda_o);
  always #50 clk_sys_i = ~clk_sys_i;
  pis_i2c_slave DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .standby_i(standby_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .bus_busy_o(bus_busy_o),
    .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .reg_flat_o(reg_flat_o));
  pis_master_model m (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_regs;
    for (int k = 0; k < pis_pkg::NUM_REGS; k++) begin
      chk(16'(reg_flat_o[k*8+:8]), 16'(shadow[k]));
    end
  endtask : chk_regs
  task automatic load_defaults;
    foreach (shadow[k]) shadow[k] = k < 14 ? pis_pkg::REG_RESET[k] : pis_pkg::UNMAPPED_READ;
  endtask : load_defaults
  task automatic wb(input logic [7:0] b, input logic ea);
    m.xfer(b, 1'b1, rx, ack);
    chk(16'(ack), 16'(ea));
  endtask : wb
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // A stray strobe meets an unknown note and fails
  always @(posedge clk_sys_i) begin
    if (wr_strobe_o === 1'b1) begin
      chk({wr_addr_o, wr_data_o}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    end
  end
  // About 23 bytes of 72 cycles each; generous margin
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h8fe010b7));
    load_defaults();
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS, pis_pkg::RW_WRITE}, 1'b0);
    for (int k = 0; k < 5; k++) begin
      ra = 8'($urandom_range(0, 15));
      d = 8'($urandom);
      exp_q.push_back({ra, d});
      if (ra < pis_pkg::NUM_REGS) shadow[ra] = d;
      wb(ra, 1'b0);
      wb(d, 1'b0);
    end
    m.stop();
    repeat (4) @(posedge clk_sys_i);
    chk(16'(bus_busy_o), 16'h0000);
    chk(16'(exp_q.size()), 16'h0000);
    chk_regs();
    $display("test write done");
    ra = 8'($urandom_range(0, 13));
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS, pis_pkg::RW_WRITE}, 1'b0);
    wb(ra, 1'b0);
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS, pis_pkg::RW_READ}, 1'b0);
    for (int k = 0; k < 3; k++) begin
      m.xfer(8'hff, k == 2, rx, ack);
      chk(16'(rx), 16'(shadow[ra+k]));
    end
    m.stop();
    $display("test read done");
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS ^ 7'($urandom_range(1, 127)), 1'b0}, 1'b1);
    wb(8'h02, 1'b1);
    m.stop();
    $display("test foreign address done");
    standby_i <= 1'b1;
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS, pis_pkg::RW_WRITE}, 1'b1);
    chk(16'(bus_busy_o), 16'h0000);
    m.stop();
    standby_i <= 1'b0;
    $display("test standby done");
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    load_defaults();
    @(posedge clk_sys_i);
    chk_regs();
    chk(16'(bus_busy_o), 16'h0000);
    repeat (4) @(posedge clk_sys_i);
    ra = 8'($urandom_range(0, 13));
    d = 8'($urandom);
    exp_q.push_back({ra, d});
    shadow[ra] = d;
    m.start();
    wb({pis_pkg::DEVICE_BUS_ADDRESS, pis_pkg::RW_WRITE}, 1'b0);
    wb(ra, 1'b0);
    wb(d, 1'b0);
    m.stop();
    repeat (4) @(posedge clk_sys_i);
    chk_regs();
    chk(16'(exp_q.size()), 16'h0000);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : test_pmic_i2c_register_slave
